//--- verilog/ldr_regs.svh
/*
  ldr_regs.svh: constants for the processor dma channel block (flag
  positions, fifo geometry, size codes, byte enables, reset values).
  assumes: included by bare name, definitions only.
*/
`ifndef LDR_REGS_SVH
`define LDR_REGS_SVH

// positions of the four channel status flags
`define LDR_FLAG_LBERR   0
`define LDR_FLAG_PCIERR  1
`define LDR_FLAG_RST     2
`define LDR_FLAG_DONE    3
`define LDR_NUM_FLAGS    4

// shared fifo: 256 bytes as 32-bit words
`define LDR_FIFO_BYTES   256
`define LDR_FIFO_DEPTH   64
// pci burst length in words (one cacheline)
`define LDR_CLINE_WORDS  4

// byte count width and per-transfer decrement
`define LDR_CNT_W        24
`define LDR_BYTES_WORD   24'h000004

// local transfer size codes and halfword offsets
`define LDR_SIZE_WORD    2'h0
`define LDR_SIZE_HALF    2'h2
`define LDR_OFS_FIRST    2'h0
`define LDR_OFS_SECOND   2'h2

// byte order select: 0 big-endian (reset value), 1 little-endian
`define LDR_ORDER_BIG    1'b0

// pci byte enables, active low: all four lanes
`define LDR_BE_ALL       4'h0

`endif

//--- verilog/ldr_pkg.sv
/*
  ldr_pkg: types used by the channel top (sequencer states, status flags).
  assumes: ldr_regs.svh supplies the numeric constants.
*/
package ldr_pkg;

  // channel sequencing states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_HALT,
    ST_RST_DRAIN,
    ST_RST_FLUSH
  } ldr_state_t;

  // one bit per status source
  typedef logic [3:0] ldr_flags_t;

endpackage : ldr_pkg

//--- verilog/ldr_lane_if.sv
/*
  ldr_lane_if: carrier between the channel top and the lane packer.
  assumes: both ends on the same clock; all signals already synchronised.
*/
`timescale 1ns/1ns
interface ldr_lane_if;
  logic [31:0] local_data;     // local data bus sample
  logic [1:0]  local_size;     // transfer size code
  logic [1:0]  local_addr;     // byte offset of the transfer
  logic        little_endian;  // local byte order
  logic        half_valid;     // one local transfer accepted
  logic        word_valid;     // packed pci word ready (pulse)
  logic [31:0] word_data;      // packed pci word, B3 in [31:24]
  logic [31:0] pci_rd_word;    // pci word to unpack
  logic [31:0] local_rd_data;  // unpacked local read data

  modport top (
    output local_data, local_size, local_addr, little_endian, half_valid, pci_rd_word,
    input  word_valid, word_data, local_rd_data
  );
  modport packer (
    input  local_data, local_size, local_addr, little_endian, half_valid, pci_rd_word,
    output word_valid, word_data, local_rd_data
  );
endinterface : ldr_lane_if

//--- verilog/ldr_endian.sv
/*
  ldr_endian: byte lane translation and halfword packing between the
  local bus and pci words; also unpacks a pci read word for the local bus.
  assumes: half_valid is a one-cycle pulse; size and offset are legal codes.
*/
`timescale 1ns/1ns
`include "ldr_regs.svh"
module ldr_endian (
  input  wire logic  clk,
  input  wire logic  srst,
  ldr_lane_if.packer ln
);

  logic [15:0] first_q;      // held first halfword (upper local lanes)
  logic        word_valid_q; // packed word strobe
  logic [31:0] word_q;       // packed word

  // first/second halfword and word packing
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      first_q      <= 16'h0000;
      word_valid_q <= 1'b0;
      word_q       <= 32'h00000000;
    end
    else
    begin
      word_valid_q <= 1'b0;
      if (ln.half_valid)
      begin
        if (ln.local_size == `LDR_SIZE_HALF)
        begin
          if (ln.local_addr == `LDR_OFS_FIRST)
          begin
            // first halfword only held, no fifo entry yet
            first_q <= ln.local_data[31:16];
          end
          else if (ln.local_addr == `LDR_OFS_SECOND)
          begin
            word_valid_q <= 1'b1;
            if (ln.little_endian)
              word_q <= {first_q, ln.local_data[31:16]};
            else
              word_q <= {ln.local_data[23:16], ln.local_data[31:24],
                         first_q[7:0], first_q[15:8]};
          end
        end
        else if (ln.local_size == `LDR_SIZE_WORD)
        begin
          word_valid_q <= 1'b1;
          if (ln.little_endian)
            word_q <= ln.local_data;
          else
            word_q <= {ln.local_data[7:0], ln.local_data[15:8],
                       ln.local_data[23:16], ln.local_data[31:24]};
        end
      end
    end
  end

  // read unpack: second halfword of a pci word sits at offset 10
  always_comb
  begin
    ln.local_rd_data = 32'h00000000;
    if (ln.local_size == `LDR_SIZE_HALF)
    begin
      if (ln.little_endian)
        ln.local_rd_data = ln.local_addr[1] ? {ln.pci_rd_word[15:0], 16'h0000}
                                            : {ln.pci_rd_word[31:16], 16'h0000};
      else
        ln.local_rd_data = ln.local_addr[1]
          ? {ln.pci_rd_word[23:16], ln.pci_rd_word[31:24], 16'h0000}
          : {ln.pci_rd_word[7:0], ln.pci_rd_word[15:8], 16'h0000};
    end
    else if (ln.little_endian)
      ln.local_rd_data = ln.pci_rd_word;
    else
      ln.local_rd_data = {ln.pci_rd_word[7:0], ln.pci_rd_word[15:8],
                          ln.pci_rd_word[23:16], ln.pci_rd_word[31:24]};
  end

  assign ln.word_valid = word_valid_q;
  assign ln.word_data  = word_q;

endmodule : ldr_endian

//--- verilog/ldr_dma_channel.sv
/*
  ldr_dma_channel: processor dma channel core. local transfers fill the
  shared fifo, words burst out to a pci master, with error halt, channel
  reset sequencing, status flags and interrupt routing.
  assumes: software-side controls are one-cycle pulses on clk; local pins
  are asynchronous; the pci master side is logic on clk.
*/
// Behaviour
// - four sticky status flags, write one clears
// - per source enable, direction and pending bits
// - error halt never resumes; reset needed first
// - channel errors never touch slave channel
// - reset request ignored while channel inactive
// - reset first drops the dma request
// - reset ends writes at cacheline, reads immediately
// - fifo flushed only after frame released
// - reset ends: active clear, reset flag set
// - reset keeps address, count, other fields
// - pci little-endian; local order selectable, big default
// - big swaps lanes, little keeps lanes
// - byte order setting goes to every channel
// - halfword pairs pack into one fifo word
// - little halfwords: B3 B2 then B1 B0
// - big halfwords: B0 B1 then B2 B3
// - little words pass straight across
// - big words reverse all four lanes
// - one shared fifo, never both channels
// - other channel: direct or linked-list mode
// - command packets cannot start this channel
// - count drops four per word, done at zero
// - request data until fifo full
`timescale 1ns/1ns
`include "ldr_regs.svh"
module ldr_dma_channel #(
  parameter int DEPTH = `LDR_FIFO_DEPTH,   // fifo words
  parameter int CLINE = `LDR_CLINE_WORDS   // words per pci burst
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        cfg_load,                  // load address and count
  input  wire logic [31:0] cfg_pci_addr,              // new pci address
  input  wire logic [23:0] cfg_byte_count,            // new byte count
  input  wire logic        go_pulse,                  // start request
  input  wire logic        go_from_packet,            // start came from a command packet
  input  wire logic        other_channel_busy,        // register-programmed channel busy
  input  wire logic        channel_reset_request,     // write of one to reset request
  input  wire logic        status_clear,              // status write strobe
  input  wire logic [3:0]  status_clear_mask,         // ones clear flags
  input  wire logic [3:0]  irq_enable,                // local,pci,reset,done enables
  input  wire logic [3:0]  irq_direction,             // 1 routes to pci side
  input  wire logic        local_byte_order_select,   // 1 little-endian
  input  wire logic        pci_read_mode,             // pci side is reading
  input  wire logic        dma_acknowledge_in_n,      // local ack pin
  input  wire logic [31:0] local_data_in,             // local data pins
  input  wire logic [1:0]  local_transfer_size,       // local size pins
  input  wire logic [1:0]  local_addr_in,             // local address low bits
  input  wire logic        local_bus_error_in,        // local bus error pin
  input  wire logic        pci_word_taken,            // pci master used the word
  input  wire logic        pci_error,                 // pci error on this channel
  input  wire logic        pci_rd_valid,              // pci read word arrives
  input  wire logic [31:0] pci_rd_data,               // pci read word
  output logic             dma_request_out_n,         // local request, active low
  output logic             pci_frame_n,               // burst frame, active low
  output logic             pci_word_valid,            // word offered
  output logic [31:0]      pci_data,                  // word to pci
  output logic [3:0]       pci_byte_en_n,             // pci byte enables
  output logic [31:0]      pci_address_register,      // running pci address
  output logic [23:0]      byte_count_register,       // remaining bytes
  output logic [3:0]       channel_flags,             // local,pci,reset,done
  output logic             channel_active_flag,       // transfer in progress
  output logic [3:0]       irq_pending,               // enabled pending sources
  output logic             irq_pci,                   // interrupt to pci side
  output logic             irq_local,                 // interrupt to local side
  output logic             local_byte_order,          // order for all channels
  output logic [31:0]      local_rd_data              // unpacked read data
);

  localparam int PW = $clog2(DEPTH);

  ldr_pkg::ldr_state_t state_q;          // channel sequencer
  ldr_pkg::ldr_flags_t flags_q;          // sticky status
  ldr_pkg::ldr_flags_t flag_set;         // hardware events this cycle
  logic [31:0]         mem [DEPTH];      // shared fifo storage
  logic [PW-1:0]       wr_ptr_q;         // fifo write pointer
  logic [PW-1:0]       rd_ptr_q;         // fifo read pointer
  logic [PW:0]         fill_q;           // fifo word count
  logic                ack_s1_q;         // ack sync stage one
  logic                ack_s2_q;         // ack sync stage two
  logic                ack_prev_q;       // for falling edge
  logic                err_s1_q;         // local error sync one
  logic                err_s2_q;         // local error sync two
  logic [35:0]         bus_s1_q;         // data, size, addr sync one
  logic [35:0]         bus_s2_q;         // data, size, addr sync two
  logic                dma_request_out_n_q;         // request pin register
  logic                frame_n_q;        // frame register
  logic                wvalid_q;         // word offered
  logic [31:0]         pdata_q;          // word to pci
  logic [31:0]         paddr_q;          // pci address
  logic [23:0]         count_q;          // remaining bytes
  logic                active_q;         // channel active
  logic [3:0]          pend_q;           // pending interrupts
  logic                irq_pci_q;        // pci side interrupt
  logic                irq_loc_q;        // local side interrupt
  logic                order_q;          // byte order out
  logic [31:0]         rd_word_q;        // last pci read word
  logic [31:0]         rd_out_q;         // unpacked read data
  logic [PW:0]         burst_q;          // words in this burst
  logic                fifo_full;
  logic                take;             // word consumed this cycle
  logic                push;             // packed word enters fifo
  logic                accept;           // local transfer accepted
  logic                burst_end;        // cacheline boundary or the last fifo word taken
  logic                start_ok;         // go accepted

  ldr_lane_if ln ();

  // local pins pass two flops before any use
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_s1_q   <= 1'b1;
      ack_s2_q   <= 1'b1;
      ack_prev_q <= 1'b1;
      err_s1_q   <= 1'b0;
      err_s2_q   <= 1'b0;
      bus_s1_q   <= 36'h000000000;
      bus_s2_q   <= 36'h000000000;
    end
    else
    begin
      ack_s1_q   <= dma_acknowledge_in_n;
      ack_s2_q   <= ack_s1_q;
      ack_prev_q <= ack_s2_q;
      err_s1_q   <= local_bus_error_in;
      err_s2_q   <= err_s1_q;
      bus_s1_q   <= {local_data_in, local_transfer_size, local_addr_in};
      bus_s2_q   <= bus_s1_q;
    end
  end

  // data passes the same two stages as ack, so they stay aligned
  assign fifo_full = (fill_q == (PW+1)'(DEPTH));
  assign accept    = ack_prev_q && !ack_s2_q && state_q == ldr_pkg::ST_RUN && !fifo_full;
  assign push      = ln.word_valid && state_q == ldr_pkg::ST_RUN && !fifo_full;
  assign take      = pci_word_taken && wvalid_q;
  assign burst_end = take && (burst_q == (PW+1)'(CLINE - 1) || fill_q == (PW+1)'(1));
  assign start_ok  = go_pulse && !go_from_packet && !other_channel_busy;

  assign ln.local_data    = bus_s2_q[35:4];
  assign ln.local_size    = bus_s2_q[3:2];
  assign ln.local_addr    = bus_s2_q[1:0];
  assign ln.little_endian = order_q;
  assign ln.half_valid    = accept;
  assign ln.pci_rd_word   = rd_word_q;

  ldr_endian u_endian (
    .clk  (clk),
    .srst (srst),
    .ln   (ln)
  );

  // hardware events feeding the sticky flags
  always_comb
  begin
    flag_set = 4'h0;
    flag_set[`LDR_FLAG_LBERR]  = err_s2_q && state_q == ldr_pkg::ST_RUN;
    flag_set[`LDR_FLAG_PCIERR] = pci_error && state_q == ldr_pkg::ST_RUN;
    flag_set[`LDR_FLAG_RST]    = state_q == ldr_pkg::ST_RST_FLUSH;
    flag_set[`LDR_FLAG_DONE]   = take && count_q == `LDR_BYTES_WORD;
  end

  // sticky flags: a set in the same cycle as its clear wins
  always_ff @(posedge clk)
  begin
    if (srst)
      flags_q <= 4'h0;
    else if (status_clear)
      flags_q <= (flags_q & ~status_clear_mask) | flag_set;
    else
      flags_q <= flags_q | flag_set;
  end

  // channel sequencer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q  <= ldr_pkg::ST_IDLE;
      active_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ldr_pkg::ST_IDLE:
        begin
          if (start_ok && count_q != 24'h000000)
          begin
            state_q  <= ldr_pkg::ST_RUN;
            active_q <= 1'b1;
          end
        end
        ldr_pkg::ST_RUN:
        begin
          if (channel_reset_request)
            state_q <= ldr_pkg::ST_RST_DRAIN;
          else if (flag_set[`LDR_FLAG_LBERR] || flag_set[`LDR_FLAG_PCIERR])
            state_q <= ldr_pkg::ST_HALT;
          else if (flag_set[`LDR_FLAG_DONE])
          begin
            state_q  <= ldr_pkg::ST_IDLE;
            active_q <= 1'b0;
          end
        end
        ldr_pkg::ST_HALT:
        begin
          // clearing an error flag does not resume the transfer
          if (channel_reset_request)
            state_q <= ldr_pkg::ST_RST_DRAIN;
        end
        ldr_pkg::ST_RST_DRAIN:
        begin
          if (frame_n_q || pci_read_mode || burst_end)
            state_q <= ldr_pkg::ST_RST_FLUSH;
        end
        ldr_pkg::ST_RST_FLUSH:
        begin
          state_q  <= ldr_pkg::ST_IDLE;
          active_q <= 1'b0;
        end
        default:
          state_q <= ldr_pkg::ST_IDLE;
      endcase
    end
  end

  // local request: asserted while running with room; reset request while
  // idle never reaches here, so it leaves the pin alone
  always_ff @(posedge clk)
  begin
    if (srst)
      dma_request_out_n_q <= 1'b1;
    else if (state_q == ldr_pkg::ST_RUN && !channel_reset_request && !fifo_full
             && !flag_set[`LDR_FLAG_LBERR] && !flag_set[`LDR_FLAG_PCIERR]
             && !flag_set[`LDR_FLAG_DONE])
      dma_request_out_n_q <= 1'b0;
    else
      dma_request_out_n_q <= 1'b1;
  end

  // fifo storage; writes only, no reset needed for the array
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_q] <= ln.word_data;
  end

  // fifo pointers; flush only once frame is released
  always_ff @(posedge clk)
  begin
    if (srst || state_q == ldr_pkg::ST_RST_FLUSH)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q   <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (take)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      fill_q <= fill_q + (PW+1)'(push) - (PW+1)'(take);
    end
  end

  // pci burst framing: a cacheline or the tail of the count
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      frame_n_q <= 1'b1;
      burst_q   <= '0;
    end
    else if (!frame_n_q)
    begin
      if (state_q == ldr_pkg::ST_HALT || flag_set[`LDR_FLAG_PCIERR]
          || (state_q == ldr_pkg::ST_RST_DRAIN && pci_read_mode))
        frame_n_q <= 1'b1;
      else if (burst_end)
        frame_n_q <= 1'b1;
      if (take)
        burst_q <= burst_q + 1'b1;
    end
    else if (state_q == ldr_pkg::ST_RUN && !channel_reset_request && fill_q != '0
             && (fill_q >= (PW+1)'(CLINE) || {2'b00, fill_q, 2'b00} >= count_q))
    begin
      frame_n_q <= 1'b0;
      burst_q   <= '0;
    end
  end

  // word offer: drops a cycle after each take so data can refresh
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wvalid_q <= 1'b0;
      pdata_q  <= 32'h00000000;
    end
    else
    begin
      pdata_q <= mem[rd_ptr_q];
      if (take || burst_end)
        wvalid_q <= 1'b0;
      else
        wvalid_q <= !frame_n_q && fill_q != '0 && state_q != ldr_pkg::ST_HALT
                    && state_q != ldr_pkg::ST_RST_FLUSH;
    end
  end

  // address and count: only loads and transfers move them
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      paddr_q <= 32'h00000000;
      count_q <= 24'h000000;
    end
    else if (cfg_load && !active_q)
    begin
      paddr_q <= cfg_pci_addr;
      count_q <= cfg_byte_count;
    end
    else if (take)
    begin
      // address wraps at the 24-bit boundary
      paddr_q <= {paddr_q[31:24], paddr_q[23:0] + `LDR_BYTES_WORD};
      count_q <= count_q - `LDR_BYTES_WORD;
    end
  end

  // interrupt pending and routing; errors stay inside this channel
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pend_q    <= 4'h0;
      irq_pci_q <= 1'b0;
      irq_loc_q <= 1'b0;
    end
    else
    begin
      pend_q    <= flags_q & irq_enable;
      irq_pci_q <= |(flags_q & irq_enable & irq_direction);
      irq_loc_q <= |(flags_q & irq_enable & ~irq_direction);
    end
  end

  // byte order broadcast and read unpack
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      order_q   <= `LDR_ORDER_BIG;
      rd_word_q <= 32'h00000000;
      rd_out_q  <= 32'h00000000;
    end
    else
    begin
      order_q  <= local_byte_order_select;
      rd_out_q <= ln.local_rd_data;
      if (pci_rd_valid)
        rd_word_q <= pci_rd_data;
    end
  end

  assign dma_request_out_n    = dma_request_out_n_q;
  assign pci_frame_n          = frame_n_q;
  assign pci_word_valid       = wvalid_q;
  assign pci_data             = pdata_q;
  assign pci_byte_en_n        = `LDR_BE_ALL;
  assign pci_address_register = paddr_q;
  assign byte_count_register  = count_q;
  assign channel_flags        = flags_q;
  assign channel_active_flag  = active_q;
  assign irq_pending          = pend_q;
  assign irq_pci              = irq_pci_q;
  assign irq_local            = irq_loc_q;
  assign local_byte_order     = order_q;
  assign local_rd_data        = rd_out_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence idle_reset_req;
    !active_q && channel_reset_request;
  endsequence
  sequence reset_entry;
    active_q && channel_reset_request && state_q inside {ldr_pkg::ST_RUN, ldr_pkg::ST_HALT};
  endsequence
  // drain, then the single flush cycle
  sequence reset_finish;
    state_q == ldr_pkg::ST_RST_DRAIN ##[1:8] state_q == ldr_pkg::ST_RST_FLUSH;
  endsequence

  reset_ignored_a: assert property (idle_reset_req |=> state_q == $past(state_q))
    else $error("reset request acted while inactive");
  dma_request_out_on_reset_a: assert property (reset_entry |=> dma_request_out_n)
    else $error("request kept during reset");
  read_frame_drop_a: assert property (state_q == ldr_pkg::ST_RST_DRAIN && pci_read_mode
    |=> pci_frame_n)
    else $error("read frame not dropped at reset");
  flush_after_frame_a: assert property (state_q == ldr_pkg::ST_RST_FLUSH |-> pci_frame_n)
    else $error("fifo flushed with frame held");
  reset_done_a: assert property (reset_entry ##1 reset_finish |=> !active_q
    && flags_q[`LDR_FLAG_RST])
    else $error("reset did not complete");
  halt_hold_a: assert property (state_q == ldr_pkg::ST_HALT && !channel_reset_request
    |=> state_q == ldr_pkg::ST_HALT && dma_request_out_n)
    else $error("halted channel resumed");
  count_keep_a: assert property (state_q == ldr_pkg::ST_RST_FLUSH
    |=> $stable(count_q) && $stable(paddr_q))
    else $error("reset altered address or count");
  clear_w1c_a: assert property (status_clear |=> (flags_q & ~$past(status_clear_mask))
    == (($past(flags_q) | $past(flag_set)) & ~$past(status_clear_mask)))
    else $error("zero write disturbed a flag");
  count_step_a: assert property (take && !cfg_load |=> count_q == $past(count_q)
    - `LDR_BYTES_WORD)
    else $error("count not reduced by four");
  full_dma_request_out_a: assert property (fifo_full |=> dma_request_out_n)
    else $error("request held with full fifo");

endmodule : ldr_dma_channel

//--- verif/ldr_lbus_model.sv
/*
  ldr_lbus_model: local dma controller, one word per enable.
  assumes: req_n active low from the channel; pins are asynchronous.
*/
`timescale 1ns/1ns
module ldr_lbus_model (
  input  wire logic        clk,
  input  wire logic        req_n,  // request, active low
  input  wire logic        en,     // allow one word
  input  wire logic        half,   // 16-bit port
  input  wire logic [31:0] word,   // word to hand over
  output logic             ack_n,  // acknowledge, active low
  output logic [31:0]      data,   // data lanes
  output logic [1:0]       size,   // size code
  output logic [1:0]       addr    // offset
);
  // one ack pulse per unit; data held 4 clocks, then scrambled
  initial
  begin
    ack_n = 1'b1;
    {data, size, addr} = '0;
    forever
    begin
      @(negedge clk);
      if (en && !req_n)
      begin
        for (int i = 0; i <= int'(half); i++)
        begin
          data = half ? {(i != 0 ? word[15:0] : word[31:16]), 16'h0000} : word;
          size = half ? 2'h2 : 2'h0;
          addr = (i != 0) ? 2'h2 : 2'h0;
          ack_n = 1'b0;
          @(negedge clk);
          ack_n = 1'b1;
          repeat (3) @(negedge clk);
          data = ~data;  // released lines carry no stale value
          @(negedge clk);
        end
        wait (!en);
      end
    end
  end
endmodule : ldr_lbus_model

//--- verif/local_dma_error_reset_endian_tb.sv
/*
  tb: drives the channel, checks lanes, errors and channel reset.
  assumes: ldr_lbus_model stands for the local dma controller.
*/
`timescale 1ns/1ns
module local_dma_error_reset_endian_tb;
  logic clk = 0, srst = 1, cfg_load = 0, go_pulse = 0, go_from_packet = 0;
  logic other_channel_busy = 0, channel_reset_request = 0, status_clear = 0;
  logic local_byte_order_select = 0, pci_read_mode = 0, local_bus_error_in = 0;
  logic pci_word_taken = 0, pci_error = 0, pci_rd_valid = 0, en = 0, half = 0;
  logic dma_acknowledge_in_n, dma_request_out_n, pci_frame_n, pci_word_valid;
  logic channel_active_flag, irq_pci, irq_local, local_byte_order;
  logic [31:0] cfg_pci_addr = '0, pci_rd_data = '0, w = '0;
  logic [31:0] local_data_in, pci_data, pci_address_register, local_rd_data;
  logic [23:0] cfg_byte_count = '0, byte_count_register;
  logic [3:0]  status_clear_mask = '0, irq_enable = '0, irq_direction = '0;
  logic [3:0]  pci_byte_en_n, channel_flags, irq_pending;
  logic [1:0]  local_transfer_size, local_addr_in;
  int err_total = 0, cmp_count = 0;

  ldr_dma_channel u_dut (.*);
  ldr_lbus_model u_lbus (.clk, .req_n(dma_request_out_n), .en, .half, .word(w),
    .ack_n(dma_acknowledge_in_n), .data(local_data_in), .size(local_transfer_size),
    .addr(local_addr_in));

  // free-running 25 MHz clock
  initial forever #20 clk = ~clk;

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse

  task start(input logic [23:0] n);
    @(negedge clk) cfg_byte_count = n;
    cfg_load = 1'b1;
    @(negedge clk) cfg_load = 1'b0;
    pulse(go_pulse);
  endtask : start

  task clear(input logic [3:0] m);
    status_clear_mask = m;
    pulse(status_clear);
  endtask : clear

  // one word through the lanes, burst to pci, done
  task xfer(input logic le, input logic hf, input logic [31:0] d);
    logic [31:0] e;
    e = le ? d : {d[7:0], d[15:8], d[23:16], d[31:24]};
    local_byte_order_select = le;
    half = hf;
    w = d;
    start(24'h000004);
    en = 1'b1;
    for (int i = 0; i < 80 && pci_word_valid !== 1'b1; i++) @(negedge clk);
    chk("data", pci_data, e);
    chk("be", pci_byte_en_n, 4'h0);
    pulse(pci_word_taken);
    en = 1'b0;
    chk("count", byte_count_register, 24'h000000);
    chk("addr", pci_address_register, 32'h00000004);
    chk("done", channel_flags, 4'h8);
    clear(4'h0);
    chk("keep", channel_flags, 4'h8);
    clear(4'h8);
    chk("clr", channel_flags, 4'h0);
    pci_rd_data = d;
    pulse(pci_rd_valid);
    chk("rd", local_rd_data, hf ? {e[15:0], 16'h0000} : e);
  endtask : xfer

  // packet start refused, idle reset ignored, error halt, channel reset
  task err_reset;
    go_from_packet = 1'b1;
    start(24'h000010);
    chk("pkt", channel_active_flag, 1'b0);
    go_from_packet = 1'b0;
    pulse(channel_reset_request);
    chk("idle", channel_flags, 4'h0);
    irq_enable = 4'h5;
    irq_direction = 4'h4;
    start(24'h000010);
    chk("req", dma_request_out_n, 1'b0);
    local_bus_error_in = 1'b1;
    repeat (4) @(negedge clk);
    local_bus_error_in = 1'b0;
    repeat (3) @(negedge clk);
    chk("err", channel_flags, 4'h1);
    chk("halt", dma_request_out_n, 1'b1);
    chk("irql", {irq_pci, irq_local}, 2'h1);
    chk("pend", irq_pending, 4'h1);
    clear(4'h1);
    chk("stay", channel_active_flag, 1'b1);
    pulse(channel_reset_request);
    repeat (3) @(negedge clk);
    chk("rst", channel_flags, 4'h4);
    chk("act", channel_active_flag, 1'b0);
    chk("cnt", byte_count_register, 24'h000010);
    chk("irqp", {irq_pci, irq_local}, 2'h2);
    clear(4'hf);
    irq_enable = 4'h0;
  endtask : err_reset

  // shared fifo refusal, reset of a running channel, pci error halt
  task busy_reset;
    other_channel_busy = 1'b1;
    start(24'h000010);
    chk("busy", channel_active_flag, 1'b0);
    other_channel_busy = 1'b0;
    pulse(go_pulse);
    chk("run", dma_request_out_n, 1'b0);
    pci_read_mode = 1'b1;
    pulse(channel_reset_request);
    chk("drop", dma_request_out_n, 1'b1);
    chk("rst2", {channel_active_flag, channel_flags}, 5'h04);
    pci_read_mode = 1'b0;
    pulse(go_pulse);
    pulse(pci_error);
    chk("perr", channel_flags, 4'h6);
    pulse(channel_reset_request);
    clear(4'hf);
  endtask : busy_reset

  task summarize;
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // watchdog, well beyond the expected run
  initial
  begin
    repeat (6000) @(posedge clk);
    err_total++;
    summarize();
  end

  // main sequence
  initial
  begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk("order", local_byte_order, 1'b0);
    err_reset();
    busy_reset();
    for (int k = 0; k < 4; k++) xfer(k[0], k[1], 32'ha1b2c3d4 + k);
    summarize();
  end
endmodule : local_dma_error_reset_endian_tb
